// ===== core/bitskip_exec.sv
// Execution unit for single-bit and conditional-skip instructions.
// Assumes one instruction per i_valid cycle, decoded fields on plain ports,
// and port pins that are asynchronous to i_clk.
// Data memory is not reset; write a byte before reading it.
`timescale 1ns/1ps
`include "bitskip_regs.svh"
module bitskip_exec
    import bitskip_pkg::*;
#(
    parameter int MEM_DEPTH = 64
) (
    input  wire logic       i_clk,               // System clock, 250 MHz
    input  wire logic       i_resetn,            // Async reset, active low
    input  wire logic       i_valid,             // Instruction present
    input  wire op_t        i_op,                // Instruction code
    input  wire logic [7:0] i_addr,              // I/O or memory address
    input  wire logic [2:0] i_bit,               // Selected bit n
    input  wire logic [7:0] i_imm,               // Immediate operand
    input  wire logic [7:0] i_pins,              // Port pin levels
    output logic      [7:0] o_working_register,  // Working register
    output logic      [3:0] o_flags,             // OV, AC, C, Z
    output logic      [7:0] o_port_out,          // Port output latch
    output logic      [7:0] o_port_oe,           // Port direction, 1 drives
    output logic            o_skip_pending,      // Next instruction cancelled
    output logic            o_retired,           // Instruction executed
    output logic            o_cancelled,         // Instruction skipped
    output logic      [7:0] o_read_data          // Read result
);
    localparam int MEM_AW = $clog2(MEM_DEPTH);

    logic [7:0]  mem_q [MEM_DEPTH];
    logic [7:0]  pins_sync;
    logic [3:0]  flags_q;
    logic [3:0]  flags_d;
    logic [7:0]  wreg_q;
    logic [7:0]  wreg_d;
    logic [7:0]  port_data_q;
    logic [7:0]  port_data_d;
    logic [7:0]  port_dir_q;
    logic [7:0]  port_dir_d;
    logic        skip_q;
    logic        skip_d;
    logic        exec;
    logic [7:0]  mask;
    logic [7:0]  io_view;
    logic [7:0]  io_latch;
    logic [7:0]  io_wdata;
    logic        io_wen;
    logic [7:0]  mem_rd;
    logic [7:0]  mem_wdata;
    logic        mem_wen;
    logic [7:0]  read_d;
    logic        read_en;
    logic        arith_inc;
    logic [7:0]  arith_b;
    logic [7:0]  arith_res;
    logic        arith_z;
    logic        arith_c;
    logic        arith_ac;
    logic        arith_ov;
    logic [MEM_AW-1:0] mem_idx;

    // Value that software sees when it reads an I/O address
    function automatic logic [7:0] io_read(input logic [7:0] addr,
                                            input logic [3:0] flags,
                                            input logic [7:0] data,
                                            input logic [7:0] dir,
                                            input logic [7:0] pins);
        logic [7:0] val;
        val = 8'h00;
        case (addr)
            `BSK_IO_FLAG:      val = {4'h0, flags};
            `BSK_IO_PORT_DATA: val = (data & dir) | (pins & ~dir);
            `BSK_IO_PORT_DIR:  val = dir;
            default:           val = 8'h00;
        endcase
        return val;
    endfunction

    // One-hot mask for bit n
    function automatic logic [7:0] bit_mask(input logic [2:0] n);
        return 8'h01 << n;
    endfunction

    // Compares whose operand comes from data memory
    function automatic logic is_mem_compare(input op_t op);
        return (op == OP_CEQ_SKIP_MEM) || (op == OP_CNE_SKIP_MEM);
    endfunction

    // Pins are asynchronous: two flops before any logic reads them
    bitskip_pin_sync #(
        .WIDTH (8)
    ) u_pin_sync (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_pins   (i_pins),
        .o_pins   (pins_sync)
    );

    // One subtractor serves compares; increment ignores the operand
    bitskip_arith u_arith (
        .i_inc    (arith_inc),
        .i_a      (wreg_q),
        .i_b      (arith_b),
        .o_result (arith_res),
        .o_zero   (arith_z),
        .o_carry  (arith_c),
        .o_half   (arith_ac),
        .o_range  (arith_ov)
    );

    // A pending skip swallows the next valid instruction
    assign exec    = i_valid & ~skip_q;
    assign mask    = bit_mask(i_bit);
    // Combinational memory read keeps read-modify-write in one cycle
    assign mem_idx = i_addr[MEM_AW-1:0];
    assign mem_rd  = mem_q[mem_idx];
    assign io_view = io_read(i_addr, flags_q, port_data_q, port_dir_q, pins_sync);

    // Read-modify-write base: port data uses its latch, not the pins
    assign io_latch = (i_addr == `BSK_IO_PORT_DATA) ? port_data_q : io_view;

    assign arith_inc = (i_op == OP_INC_ZERO_SKIP);
    assign arith_b   = is_mem_compare(i_op) ? mem_rd : i_imm;

    // Instruction decode
    always_comb begin
        io_wen    = 1'b0;
        io_wdata  = io_latch;
        mem_wen   = 1'b0;
        mem_wdata = mem_rd;
        wreg_d    = wreg_q;
        skip_d    = 1'b0;
        read_en   = 1'b0;
        read_d    = 8'h00;
        if (exec) begin
            case (i_op)
                OP_BIT_CLEAR_IO: begin
                    io_wen   = 1'b1;
                    io_wdata = io_latch & ~mask;
                end
                OP_BIT_SET_IO: begin
                    io_wen   = 1'b1;
                    io_wdata = io_latch | mask;
                end
                OP_SWAP_CARRY_IO: begin
                    io_wen   = 1'b1;
                    io_wdata = flags_q[`BSK_FLAG_C] ? (io_latch | mask)
                                                    : (io_latch & ~mask);
                end
                OP_BIT_CLEAR_MEM: begin
                    mem_wen   = 1'b1;
                    mem_wdata = mem_rd & ~mask;
                end
                OP_BIT_SET_MEM: begin
                    mem_wen   = 1'b1;
                    mem_wdata = mem_rd | mask;
                end
                OP_CEQ_SKIP_IMM,
                OP_CEQ_SKIP_MEM: begin
                    skip_d = arith_z;
                end
                OP_CNE_SKIP_IMM,
                OP_CNE_SKIP_MEM: begin
                    skip_d = ~arith_z;
                end
                OP_TEST_LOW_SKIP_IO: begin
                    skip_d = ~io_view[i_bit];
                end
                OP_TEST_HIGH_SKIP_IO: begin
                    skip_d = io_view[i_bit];
                end
                OP_TEST_LOW_SKIP_MEM: begin
                    skip_d = ~mem_rd[i_bit];
                end
                OP_TEST_HIGH_SKIP_MEM: begin
                    skip_d = mem_rd[i_bit];
                end
                OP_INC_ZERO_SKIP: begin
                    wreg_d = arith_res;
                    skip_d = arith_z;
                end
                OP_MOV_IMM: begin
                    wreg_d = i_imm;
                end
                OP_WRITE_IO: begin
                    io_wen   = 1'b1;
                    io_wdata = i_imm;
                end
                OP_WRITE_MEM: begin
                    mem_wen   = 1'b1;
                    mem_wdata = i_imm;
                end
                OP_READ_IO: begin
                    read_en = 1'b1;
                    read_d  = io_view;
                end
                OP_READ_MEM: begin
                    read_en = 1'b1;
                    read_d  = mem_rd;
                end
                default: begin
                    skip_d = 1'b0;
                end
            endcase
        end
    end

    // Next flag value; flag register is also an I/O location
    always_comb begin
        flags_d = flags_q;
        if (io_wen && i_addr == `BSK_IO_FLAG) begin
            flags_d = io_wdata[3:0];
        end
        if (exec) begin
            case (i_op)
                OP_SWAP_CARRY_IO: begin
                    // Readback is latch for outputs, pin for inputs
                    flags_d[`BSK_FLAG_C] = io_view[i_bit];
                end
                OP_CEQ_SKIP_IMM,
                OP_CEQ_SKIP_MEM,
                OP_CNE_SKIP_IMM,
                OP_CNE_SKIP_MEM,
                OP_INC_ZERO_SKIP: begin
                    flags_d[`BSK_FLAG_Z]  = arith_z;
                    flags_d[`BSK_FLAG_C]  = arith_c;
                    flags_d[`BSK_FLAG_AC] = arith_ac;
                    flags_d[`BSK_FLAG_OV] = arith_ov;
                end
                default: begin
                    flags_d = flags_d;
                end
            endcase
        end
    end

    // Port latch and direction writes
    always_comb begin
        port_data_d = port_data_q;
        port_dir_d  = port_dir_q;
        if (io_wen && i_addr == `BSK_IO_PORT_DATA) begin
            port_data_d = io_wdata;
        end
        if (io_wen && i_addr == `BSK_IO_PORT_DIR) begin
            port_dir_d = io_wdata;
        end
    end

    // Flag register; carry sits at bit 1
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            flags_q <= `BSK_RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Compares never write the working register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wreg_q <= `BSK_RST_WREG;
        end else begin
            wreg_q <= wreg_d;
        end
    end

    // Direction resets to all inputs so no pin drives early
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            port_data_q <= `BSK_RST_PORT_DATA;
            port_dir_q  <= `BSK_RST_PORT_DIR;
        end else begin
            port_data_q <= port_data_d;
            port_dir_q  <= port_dir_d;
        end
    end

    // Data memory, no reset
    always_ff @(posedge i_clk) begin
        if (mem_wen) begin
            mem_q[mem_idx] <= mem_wdata;
        end
    end

    // Skip lasts for exactly one following instruction
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            skip_q <= 1'b0;
        end else if (i_valid) begin
            skip_q <= skip_d;
        end
    end

    // Top-level outputs mirror the next state so they stay registered
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_working_register <= `BSK_RST_WREG;
            o_flags            <= `BSK_RST_FLAGS;
        end else begin
            o_working_register <= wreg_d;
            o_flags            <= flags_d;
        end
    end

    // Port pins follow the latch and direction
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_port_out <= `BSK_RST_PORT_DATA;
            o_port_oe  <= `BSK_RST_PORT_DIR;
        end else begin
            o_port_out <= port_data_d;
            o_port_oe  <= port_dir_d;
        end
    end

    // Pending skip as seen from outside
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_skip_pending <= 1'b0;
        end else begin
            o_skip_pending <= i_valid ? skip_d : skip_q;
        end
    end

    // Status pulses for one cycle after each valid instruction: retired if executed, cancelled if skipped
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_retired   <= 1'b0;
            o_cancelled <= 1'b0;
        end else begin
            o_retired   <= exec;
            o_cancelled <= i_valid & skip_q;
        end
    end

    // Read result holds until the next read
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_read_data <= 8'h00;
        end else if (read_en) begin
            o_read_data <= read_d;
        end
    end
endmodule // bitskip_exec

// ===== core/bitskip_regs.svh
// Constants for the bit-operation and conditional-skip execution unit.
// Assumes one 250 MHz clock; included by bare name from core files.
// How it works
// - Bit clear on I/O drives only bit n low
// - Bit set on I/O drives only bit n high
// - Exchange I/O bit n with carry in one instruction
// - Output pin bit receives the old carry
// - Input pin level is loaded into carry
// - Carry is bit 1 of flag register
// - Bit clear on memory clears only bit n
// - Bit set on memory sets only bit n
// - Bit set, clear, test keep all flags unless set or clear targets the flag register
// - Equal compare skips next when equal
// - Unequal compare skips next when different
// - Compares set flags like subtraction, no writeback
// - I/O test-low skips when bit is zero
// - I/O test-high skips when bit is one
// - Memory test-low skips when bit is zero
// - Memory test-high skips when bit is one
// - Increment working register, flags, skip on zero
`ifndef BITSKIP_REGS_SVH
`define BITSKIP_REGS_SVH

// I/O space map
`define BSK_IO_FLAG       8'h00
`define BSK_IO_PORT_DATA  8'h10
`define BSK_IO_PORT_DIR   8'h11

// Flag register bit positions
`define BSK_FLAG_Z        0
`define BSK_FLAG_C        1
`define BSK_FLAG_AC       2
`define BSK_FLAG_OV       3

// Reset values
`define BSK_RST_FLAGS     4'h0
`define BSK_RST_WREG      8'h00
`define BSK_RST_PORT_DATA 8'h00
`define BSK_RST_PORT_DIR  8'h00

`endif

// ===== core/bitskip_pkg.sv
// Types shared by the bit-operation and conditional-skip execution unit.
// Assumes nothing of its surroundings.
package bitskip_pkg;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_BIT_CLEAR_IO,
        OP_BIT_SET_IO,
        OP_SWAP_CARRY_IO,
        OP_BIT_CLEAR_MEM,
        OP_BIT_SET_MEM,
        OP_CEQ_SKIP_IMM,
        OP_CEQ_SKIP_MEM,
        OP_CNE_SKIP_IMM,
        OP_CNE_SKIP_MEM,
        OP_TEST_LOW_SKIP_IO,
        OP_TEST_HIGH_SKIP_IO,
        OP_TEST_LOW_SKIP_MEM,
        OP_TEST_HIGH_SKIP_MEM,
        OP_INC_ZERO_SKIP,
        OP_MOV_IMM,
        OP_WRITE_IO,
        OP_WRITE_MEM,
        OP_READ_IO,
        OP_READ_MEM
    } op_t;

endpackage

// ===== core/bitskip_pin_sync.sv
// Two-flop synchroniser for the port pin levels.
// Assumes pins are asynchronous to i_clk.
`timescale 1ns/1ps
module bitskip_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clk,    // System clock
    input  wire logic             i_resetn, // Async reset, active low
    input  wire logic [WIDTH-1:0] i_pins,   // Raw pin levels
    output logic      [WIDTH-1:0] o_pins    // Synchronised levels
);
    logic [WIDTH-1:0] meta_q;

    for (genvar g = 0; g < WIDTH; g++) begin : g_sync
        always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                meta_q[g] <= 1'b0;
                o_pins[g] <= 1'b0;
            end else begin
                meta_q[g] <= i_pins[g];
                o_pins[g] <= meta_q[g];
            end
        end
    end
endmodule // bitskip_pin_sync

// ===== core/bitskip_arith.sv
// Eight-bit subtract or increment with the four arithmetic flags.
// Assumes a purely combinational use by the execution unit.
`timescale 1ns/1ps
module bitskip_arith (
    input  wire logic       i_inc,    // 1: a+1, 0: a-b
    input  wire logic [7:0] i_a,      // Working register value
    input  wire logic [7:0] i_b,      // Operand
    output logic      [7:0] o_result, // Result byte
    output logic            o_zero,   // Result is zero
    output logic            o_carry,  // Carry out or borrow
    output logic            o_half,   // Nibble carry or borrow
    output logic            o_range   // Signed overflow
);
    logic [8:0] full;
    logic [4:0] low;

    always_comb begin
        if (i_inc) begin
            full    = {1'b0, i_a} + 9'h001;
            low     = {1'b0, i_a[3:0]} + 5'h01;
            o_range = ~i_a[7] & full[7];
        end else begin
            full    = {1'b0, i_a} - {1'b0, i_b};
            low     = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]};
            o_range = (i_a[7] ^ i_b[7]) & (full[7] ^ i_a[7]);
        end
        o_result = full[7:0];
        o_zero   = (full[7:0] == 8'h00);
        o_carry  = full[8];
        o_half   = low[4];
    end
endmodule // bitskip_arith

// ===== verif/bitskip_exec_chk.sv
// Concurrent checks for the bit and skip execution unit.
// Assumes it is bound to bitskip_exec and sees only its ports.
`timescale 1ns/1ps
`include "bitskip_regs.svh"
module bitskip_exec_chk
    import bitskip_pkg::*;
(
    input wire logic       i_clk,              // Clock
    input wire logic       i_resetn,           // Reset, active low
    input wire logic       i_valid,            // Instruction present
    input wire op_t        i_op,               // Instruction code
    input wire logic [7:0] i_addr,             // Address
    input wire logic [2:0] i_bit,              // Bit n
    input wire logic [7:0] i_imm,              // Immediate
    input wire logic [7:0] i_pins,             // Pins
    input wire logic [7:0] o_working_register, // Working register
    input wire logic [3:0] o_flags,            // Flags
    input wire logic [7:0] o_port_out,         // Port latch
    input wire logic [7:0] o_port_oe,          // Port direction
    input wire logic       o_skip_pending,     // Skip pending
    input wire logic       o_retired,          // Executed pulse
    input wire logic       o_cancelled,        // Cancelled pulse
    input wire logic [7:0] o_read_data         // Read result
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    logic go;
    logic carry;
    assign go = i_valid && !o_skip_pending;
    assign carry = o_flags[`BSK_FLAG_C];
    sequence s_skip_taken;
        i_valid && o_skip_pending;
    endsequence
    sequence s_cancel_seen;
        o_cancelled && !o_retired && !o_skip_pending;
    endsequence
    chk_cancel_next: assert property (s_skip_taken |=> s_cancel_seen)
        else $error("skipped instruction not cancelled");
    chk_cancel_inert: assert property (s_skip_taken |=> $stable(o_working_register) && $stable(o_flags)
        && $stable(o_port_out) && $stable(o_port_oe)) else $error("cancelled instruction changed state");
    chk_retire_once: assert property (go |=> o_retired && !o_cancelled)
        else $error("executed instruction not retired");
    chk_ceq_skip: assert property (go && i_op == OP_CEQ_SKIP_IMM |=>
        o_skip_pending == ($past(o_working_register) == $past(i_imm))) else $error("equal skip wrong");
    chk_cne_skip: assert property (go && i_op == OP_CNE_SKIP_IMM |=>
        o_skip_pending != ($past(o_working_register) == $past(i_imm))) else $error("unequal skip wrong");
    chk_cmp_wreg: assert property (go && i_op inside {OP_CEQ_SKIP_IMM, OP_CEQ_SKIP_MEM, OP_CNE_SKIP_IMM,
        OP_CNE_SKIP_MEM} |=> $stable(o_working_register)) else $error("compare wrote working register");
    chk_inc_skip: assert property (go && i_op == OP_INC_ZERO_SKIP |=>
        o_working_register == $past(o_working_register) + 8'h01 && o_skip_pending == (o_working_register == 8'h00))
        else $error("increment skip wrong");
    chk_set_io: assert property (go && i_op == OP_BIT_SET_IO && i_addr == `BSK_IO_PORT_DATA |=>
        o_port_out == ($past(o_port_out) | (8'h01 << $past(i_bit)))) else $error("bit set on port wrong");
    chk_clear_io: assert property (go && i_op == OP_BIT_CLEAR_IO && i_addr == `BSK_IO_PORT_DATA |=>
        o_port_out == ($past(o_port_out) & ~(8'h01 << $past(i_bit)))) else $error("bit clear on port wrong");
    chk_swap_out: assert property (go && i_op == OP_SWAP_CARRY_IO && i_addr == `BSK_IO_PORT_DATA |=>
        o_port_out[$past(i_bit)] == $past(carry)) else $error("swap did not place carry");
    chk_bit_flags: assert property (go && i_op inside {OP_BIT_CLEAR_MEM, OP_BIT_SET_MEM, OP_TEST_LOW_SKIP_IO,
        OP_TEST_HIGH_SKIP_IO, OP_TEST_LOW_SKIP_MEM, OP_TEST_HIGH_SKIP_MEM} |=> $stable(o_flags))
        else $error("bit operation changed flags");
endmodule // bitskip_exec_chk

bind bitskip_exec bitskip_exec_chk bitskip_exec_chk_inst (.i_clk, .i_resetn, .i_valid, .i_op, .i_addr, .i_bit,
    .i_imm, .i_pins, .o_working_register, .o_flags, .o_port_out, .o_port_oe, .o_skip_pending, .o_retired,
    .o_cancelled, .o_read_data);

// ===== verif/bitskip_exec_test.sv
// Directed test of the bit and skip execution unit.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
`include "bitskip_regs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module bitskip_exec_test
    import bitskip_pkg::*;
;
    logic       i_clk;
    logic       i_resetn;
    logic       i_valid;
    op_t        i_op;
    logic [7:0] i_addr;
    logic [7:0] i_imm;
    logic [7:0] i_pins;
    logic [2:0] i_bit;
    logic [7:0] wreg;
    logic [7:0] pout;
    logic [7:0] poe;
    logic [7:0] rdata;
    logic [3:0] flags;
    logic       skip;
    logic       canc;
    logic       ret;
    int         failures;
    int         check_count;
    bitskip_exec #(.MEM_DEPTH(64)) bitskip_exec_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_valid(i_valid),
        .i_op(i_op), .i_addr(i_addr), .i_bit(i_bit), .i_imm(i_imm), .i_pins(i_pins), .o_working_register(wreg),
        .o_flags(flags), .o_port_out(pout), .o_port_oe(poe), .o_skip_pending(skip), .o_retired(ret),
        .o_cancelled(canc), .o_read_data(rdata));
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    task automatic close_out();
        if (failures == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic run(input op_t op, input logic [7:0] a, input logic [2:0] n, input logic [7:0] d);
        i_valid = 1'b1;
        i_op = op;
        i_addr = a;
        i_bit = n;
        i_imm = d;
        @(posedge i_clk);
        #1;
    endtask
    task automatic idle();
        i_valid = 1'b0;
        @(posedge i_clk);
        #1;
    endtask
    // Next instruction is cancelled exactly when a skip was expected
    task automatic follow(input logic e);
        logic [7:0] w;
        w = wreg;
        `CHK("skip", e, skip)
        run(OP_MOV_IMM, 8'h00, 3'h0, 8'h77);
        `CHK("cancel", e, canc)
        `CHK("retired", ~e, ret)
        `CHK("wreg", e ? w : 8'h77, wreg)
    endtask
    task automatic tst(input op_t op, input logic [7:0] a, input logic [2:0] n, input logic e);
        run(op, a, n, 8'h00);
        follow(e);
    endtask
    task automatic cmp(input op_t op, input logic [7:0] a, input logic [7:0] w, input logic [7:0] d,
                       input logic e, input logic [3:0] f);
        run(OP_MOV_IMM, 8'h00, 3'h0, w);
        run(op, a, 3'h0, d);
        `CHK("cmp_flags", f, flags)
        `CHK("cmp_wreg", w, wreg)
        follow(e);
    endtask
    initial begin
        #20000;
        failures++;
        close_out();
    end
    initial begin
        i_resetn = 1'b0;
        i_valid = 1'b0;
        i_op = OP_NOP;
        i_addr = 8'h00;
        i_bit = 3'h0;
        i_imm = 8'h00;
        i_pins = 8'h00;
        failures = 0;
        check_count = 0;
        repeat (10) @(posedge i_clk);
        #1;
        i_resetn = 1'b1;
        `CHK("rst_oe", 8'h00, poe)
        run(OP_WRITE_IO, `BSK_IO_PORT_DIR, 3'h0, 8'hFF);
        `CHK("oe_out", 8'hFF, poe)
        run(OP_WRITE_IO, `BSK_IO_PORT_DATA, 3'h0, 8'h5A);
        run(OP_BIT_SET_IO, `BSK_IO_PORT_DATA, 3'h0, 8'h00);
        `CHK("set_io", 8'h5B, pout)
        run(OP_BIT_CLEAR_IO, `BSK_IO_PORT_DATA, 3'h6, 8'h00);
        `CHK("clr_io", 8'h1B, pout)
        `CHK("io_flags", 4'h0, flags)
        run(OP_BIT_SET_IO, `BSK_IO_FLAG, 3'h1, 8'h00);
        `CHK("carry_set", 4'h2, flags)
        run(OP_SWAP_CARRY_IO, `BSK_IO_PORT_DATA, 3'h2, 8'h00);
        `CHK("swap_out", 8'h1F, pout)
        `CHK("swap_c0", 4'h0, flags)
        run(OP_SWAP_CARRY_IO, `BSK_IO_PORT_DATA, 3'h2, 8'h00);
        `CHK("swap_back", 8'h1B, pout)
        `CHK("swap_c1", 4'h2, flags)
        run(OP_BIT_CLEAR_IO, `BSK_IO_FLAG, 3'h1, 8'h00);
        `CHK("carry_clr", 4'h0, flags)
        i_pins = 8'h08;
        run(OP_WRITE_IO, `BSK_IO_PORT_DIR, 3'h0, 8'h00);
        repeat (3) idle();
        run(OP_SWAP_CARRY_IO, `BSK_IO_PORT_DATA, 3'h3, 8'h00);
        `CHK("swap_in", 4'h2, flags)
        tst(OP_TEST_HIGH_SKIP_IO, `BSK_IO_PORT_DATA, 3'h3, 1'b1);
        tst(OP_TEST_HIGH_SKIP_IO, `BSK_IO_PORT_DATA, 3'h2, 1'b0);
        tst(OP_TEST_LOW_SKIP_IO, `BSK_IO_PORT_DATA, 3'h2, 1'b1);
        tst(OP_TEST_LOW_SKIP_IO, `BSK_IO_PORT_DATA, 3'h3, 1'b0);
        `CHK("test_flags", 4'h2, flags)
        run(OP_WRITE_MEM, 8'h05, 3'h0, 8'hA5);
        run(OP_BIT_CLEAR_MEM, 8'h05, 3'h0, 8'h00);
        run(OP_READ_MEM, 8'h05, 3'h0, 8'h00);
        `CHK("clr_mem", 8'hA4, rdata)
        run(OP_BIT_SET_MEM, 8'h05, 3'h6, 8'h00);
        run(OP_READ_MEM, 8'h05, 3'h0, 8'h00);
        `CHK("set_mem", 8'hE4, rdata)
        tst(OP_TEST_HIGH_SKIP_MEM, 8'h05, 3'h7, 1'b1);
        tst(OP_TEST_HIGH_SKIP_MEM, 8'h05, 3'h0, 1'b0);
        tst(OP_TEST_LOW_SKIP_MEM, 8'h05, 3'h4, 1'b1);
        tst(OP_TEST_LOW_SKIP_MEM, 8'h05, 3'h2, 1'b0);
        `CHK("mem_flags", 4'h2, flags)
        run(OP_WRITE_MEM, 8'h09, 3'h0, 8'h40);
        run(OP_WRITE_MEM, 8'h0A, 3'h0, 8'h41);
        cmp(OP_CEQ_SKIP_IMM, 8'h00, 8'h40, 8'h40, 1'b1, 4'h1);
        cmp(OP_CEQ_SKIP_IMM, 8'h00, 8'h40, 8'h41, 1'b0, 4'h6);
        cmp(OP_CEQ_SKIP_MEM, 8'h09, 8'h40, 8'h00, 1'b1, 4'h1);
        cmp(OP_CEQ_SKIP_MEM, 8'h0A, 8'h40, 8'h00, 1'b0, 4'h6);
        cmp(OP_CNE_SKIP_IMM, 8'h00, 8'h40, 8'h40, 1'b0, 4'h1);
        cmp(OP_CNE_SKIP_IMM, 8'h00, 8'h40, 8'h41, 1'b1, 4'h6);
        cmp(OP_CNE_SKIP_MEM, 8'h09, 8'h40, 8'h00, 1'b0, 4'h1);
        cmp(OP_CNE_SKIP_MEM, 8'h0A, 8'h40, 8'h00, 1'b1, 4'h6);
        cmp(OP_CEQ_SKIP_IMM, 8'h00, 8'h80, 8'h01, 1'b0, 4'hC);
        // Cancelled skip instruction must not skip again
        run(OP_MOV_IMM, 8'h00, 3'h0, 8'h40);
        run(OP_CEQ_SKIP_IMM, 8'h00, 3'h0, 8'h40);
        run(OP_CEQ_SKIP_IMM, 8'h00, 3'h0, 8'h40);
        `CHK("chain_cancel", 1'b1, canc)
        follow(1'b0);
        run(OP_MOV_IMM, 8'h00, 3'h0, 8'hFF);
        run(OP_INC_ZERO_SKIP, 8'h00, 3'h0, 8'h00);
        `CHK("inc_wrap", 8'h00, wreg)
        `CHK("inc_flags0", 4'h7, flags)
        idle();
        follow(1'b1);
        run(OP_MOV_IMM, 8'h00, 3'h0, 8'h7F);
        run(OP_INC_ZERO_SKIP, 8'h00, 3'h0, 8'h00);
        `CHK("inc_ov", 8'h80, wreg)
        `CHK("inc_flags1", 4'hC, flags)
        follow(1'b0);
        idle();
        close_out();
    end
endmodule // bitskip_exec_test
